// >>> pcsp_core.sv
// Program counter, page latch and return stack sequencing
//
// How it works
// - Program counter is thirteen bits and addresses program words.
// - Low byte of the counter is readable and writable by software.
// - Upper five bits are unreadable and not directly writable; software sets them via the latch.
// - Every reset clears the upper counter bits.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Call and jump use eleven instruction bits plus latch bits 4..3.
// - Return stack holds eight thirteen-bit entries outside memory space.
// - Stack pointer has no software read or write path.
// - Call or interrupt vectoring pushes the counter onto the stack.
// - Return, literal return and interrupt return pop the stack.
// - Stack pushes and pops never change the high-address latch.
// - Stack is circular; the ninth push overwrites the first.
// - No overflow or underflow flag exists.
// - Returns restore all thirteen bits, ignoring latch page bits.
// - One 8K-word space split in 2K-word pages for branches.
`timescale 1ns/1ns
`default_nettype none
module pcsp_core #(
  parameter logic [pcsp_pkg::PC_W-1:0] INT_VECTOR = pcsp_pkg::VEC_DFLT
) (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          fetch_adv,
  input  wire logic                          jump_op,
  input  wire logic                          call_op,
  input  wire logic [pcsp_pkg::TGT_W-1:0]    branch_target,
  input  wire logic                          return_op,
  input  wire logic                          exit_with_literal_op,
  input  wire logic                          interrupt_exit_op,
  input  wire logic                          vector_op,
  input  wire logic                          low_wr,
  input  wire logic [pcsp_pkg::LOW_W-1:0]    low_wr_data,
  input  wire logic                          latch_wr,
  input  wire logic [pcsp_pkg::LATCH_W-1:0]  latch_wr_data,
  output logic      [pcsp_pkg::PC_W-1:0]     fetch_addr,
  output logic      [pcsp_pkg::LOW_W-1:0]    pc_low_byte,
  output logic      [pcsp_pkg::LATCH_W-1:0]  pc_high_latch
);
  import pcsp_pkg::*;

  logic [PC_W-1:0]    pc_reg;
  logic [PC_W-1:0]    pc_next;
  logic [LATCH_W-1:0] latch_reg;
  logic [LATCH_W-1:0] latch_next;
  logic [PC_W-1:0]    stack_top;
  logic [PTR_W-1:0]   stack_ptr;
  pcsp_act_t          act;
  logic               any_ret;
  logic               do_push;
  logic               do_pop;
  logic [PC_W-1:0]    low_load;
  logic [PC_W-1:0]    page_load;
  logic [PC_W-1:0]    seq_load;
  logic [UP_W-1:0]    pc_upper_bits;

  // Counter fields must tile the thirteen bits exactly
  if ((LOW_W + UP_W != PC_W) || (UP_MSB + 1 != UP_W) ||
      (TGT_W + PAGE_MSB - PAGE_LSB + 1 != PC_W)) begin : g_bad_split
    $error("Counter field widths do not match the counter width");
  end

  // ---------------------------------------------------------------
  // Action select: vector, call, jump, return, low write, advance
  // ---------------------------------------------------------------
  assign any_ret = return_op | exit_with_literal_op
                 | interrupt_exit_op;
  assign act = vector_op ? PCSP_VEC  :
               call_op   ? PCSP_CALL :
               jump_op   ? PCSP_JUMP :
               any_ret   ? PCSP_RET  :
               low_wr    ? PCSP_LOW  :
               fetch_adv ? PCSP_SEQ  : PCSP_HOLD;
  assign do_push = (act == PCSP_VEC) || (act == PCSP_CALL);
  assign do_pop  = (act == PCSP_RET);

  // ---------------------------------------------------------------
  // Candidate counter values
  // ---------------------------------------------------------------
  assign low_load  = {latch_reg[UP_MSB:0], low_wr_data};
  assign page_load = {latch_reg[PAGE_MSB:PAGE_LSB],
                      branch_target};
  assign seq_load  = pc_reg + PC_STEP;

  always_comb begin
    case (act)
      PCSP_VEC:  pc_next = INT_VECTOR;
      PCSP_CALL: pc_next = page_load;
      PCSP_JUMP: pc_next = page_load;
      PCSP_RET:  pc_next = stack_top;
      PCSP_LOW:  pc_next = low_load;
      PCSP_SEQ:  pc_next = seq_load;
      default:   pc_next = pc_reg;
    endcase
  end

  // Latch changes only by its own write, never by stack traffic
  assign latch_next = latch_wr ? latch_wr_data : latch_reg;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg    <= PC_RST;
      latch_reg <= LATCH_RST;
    end else begin
      pc_reg    <= pc_next;
      latch_reg <= latch_next;
    end
  end

  // Stack has no port toward software; only push and pop reach it
  pcsp_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clock     (clock),
    .rst_n     (rst_n),
    .push      (do_push),
    .pop       (do_pop),
    .push_data (pc_reg),
    .top_data  (stack_top),
    .ptr       (stack_ptr)
  );

  // ---------------------------------------------------------------
  // Outputs: upper bits leave only on the fetch address, not on a readable port
  // ---------------------------------------------------------------
  assign pc_upper_bits = pc_reg[PC_W-1:LOW_W];
  assign fetch_addr    = pc_reg;
  assign pc_low_byte   = pc_reg[LOW_W-1:0];
  assign pc_high_latch = latch_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic first_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  a_reset_upper_clear: assert property (
    first_reg |-> pc_upper_bits == '0)
    else $error("Upper counter bits not clear after reset");

  a_low_write_load: assert property (
    (act == PCSP_LOW) |=> fetch_addr ==
      {$past(latch_reg[UP_MSB:0]), $past(low_wr_data)})
    else $error("Low byte write did not load upper bits from latch");

  a_page_branch_load: assert property (
    (act == PCSP_JUMP || act == PCSP_CALL) |=>
      fetch_addr[PC_W-1:TGT_W] == $past(latch_reg[PAGE_MSB:PAGE_LSB]) &&
      fetch_addr[TGT_W-1:0] == $past(branch_target))
    else $error("Branch target not formed from page bits and operand");

  a_push_then_pop: assert property (
    (do_push ##1 do_pop) |=> fetch_addr == $past(pc_reg, 2))
    else $error("Pushed address not restored by following return");

  a_pop_pointer_dec: assert property (
    do_pop |=> stack_ptr == $past(stack_ptr) - PTR_STEP)
    else $error("Return did not pop the stack");

  a_latch_kept_stack: assert property (
    (do_push || do_pop) && !latch_wr |=> $stable(pc_high_latch))
    else $error("Stack traffic changed the high-address latch");

  a_stack_wraps: assert property (
    do_push [*8] |=> stack_ptr == $past(stack_ptr, 8))
    else $error("Stack pointer does not wrap after eight pushes");

  a_return_full_pc: assert property (
    do_pop |=> fetch_addr == $past(stack_top))
    else $error("Return did not restore the full counter");

  a_seq_carry: assert property (
    (act == PCSP_SEQ && pc_low_byte == 8'hff) |=>
      pc_upper_bits == $past(pc_upper_bits) + 5'h01 &&
      pc_low_byte == 8'h00)
    else $error("Sequential advance lost carry into upper bits");

  a_vector_entry: assert property (
    (act == PCSP_VEC) |=> fetch_addr == INT_VECTOR &&
      stack_ptr == $past(stack_ptr) + PTR_STEP)
    else $error("Vectoring did not push and branch");

  a_hold_keeps_pc: assert property (
    (act == PCSP_HOLD) |=> $stable(fetch_addr))
    else $error("Counter moved without any request");

  a_call_pushes: assert property (
    (act == PCSP_CALL) |=> stack_ptr == $past(stack_ptr) + PTR_STEP)
    else $error("Call did not push the stack");

  a_jump_no_push: assert property (
    (act == PCSP_JUMP) |=> $stable(stack_ptr))
    else $error("Jump changed the stack pointer");

  a_low_keeps_stack: assert property (
    (act == PCSP_LOW || act == PCSP_SEQ) |=> $stable(stack_ptr))
    else $error("Low byte write or advance changed the stack pointer");

  c_call_return: cover property (do_push ##[1:20] do_pop);
  c_ninth_push:  cover property (do_push [*8] ##1 do_push);
  c_low_write:   cover property (act == PCSP_LOW && latch_reg[UP_MSB:0] != '0);
  c_seq_carry:   cover property (act == PCSP_SEQ && pc_low_byte == 8'hff);
  c_vector:      cover property (act == PCSP_VEC);
endmodule
`default_nettype wire

// >>> pcsp_pkg.sv
// Constants shared by the program counter and return stack logic
`default_nettype none
package pcsp_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_W        = 13;
  localparam int LOW_W       = 8;
  localparam int UP_W        = 5;
  localparam int TGT_W       = 11;
  localparam int LATCH_W     = 8;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W       = 3;
  // ---------------------------------------------------------------
  // Field positions in the high-address latch
  // ---------------------------------------------------------------
  localparam int PAGE_MSB    = 4;
  localparam int PAGE_LSB    = 3;
  localparam int UP_MSB      = 4;
  // ---------------------------------------------------------------
  // Reset values, fixed increments and the default interrupt vector
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PC_W-1:0]    PC_STEP   = 13'h0001;
  localparam logic [PTR_W-1:0]   PTR_RST   = 3'h0;
  localparam logic [PTR_W-1:0]   PTR_STEP  = 3'h1;
  localparam logic [PC_W-1:0]    VEC_DFLT  = 13'h0004;
  // ---------------------------------------------------------------
  // Action chosen for the counter in one cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PCSP_HOLD = 3'b000,
    PCSP_SEQ  = 3'b001,
    PCSP_LOW  = 3'b010,
    PCSP_JUMP = 3'b011,
    PCSP_CALL = 3'b100,
    PCSP_VEC  = 3'b101,
    PCSP_RET  = 3'b110
  } pcsp_act_t;
endpackage
`default_nettype wire

// >>> pcsp_stack.sv
// Eight-entry circular return address stack
`timescale 1ns/1ns
`default_nettype none
module pcsp_stack #(
  parameter int DEPTH = pcsp_pkg::STACK_DEPTH,
  parameter int WIDTH = pcsp_pkg::PC_W
) (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          push,
  input  wire logic                          pop,
  input  wire logic [WIDTH-1:0]              push_data,
  output logic      [WIDTH-1:0]              top_data,
  output logic      [pcsp_pkg::PTR_W-1:0]    ptr
);
  import pcsp_pkg::*;

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic [PTR_W-1:0] top_idx;

  if (DEPTH != (1 << PTR_W)) begin : g_bad_depth
    $error("Stack depth must equal two to the pointer width");
  end

  // ---------------------------------------------------------------
  // Pointer wraps freely; no overflow or underflow indication
  // ---------------------------------------------------------------
  assign top_idx  = ptr_reg - PTR_STEP;
  assign ptr_next = push ? ptr_reg + PTR_STEP :
                    pop  ? top_idx : ptr_reg;
  assign top_data = entry_reg[top_idx];
  assign ptr      = ptr_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        entry_reg[i] <= '0;
      end else if (push && ptr_reg == PTR_W'(i)) begin
        entry_reg[i] <= push_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pcsp_decoder_model.sv
// Decoder model that turns a command code into one-cycle op strobes
`timescale 1ns/1ns
`default_nettype none
module pcsp_decoder_model (
  input  wire logic [3:0]                 op_code,
  input  wire logic [12:0]                op_arg,
  output logic                            fetch_adv,
  output logic                            jump_op,
  output logic                            call_op,
  output logic                            return_op,
  output logic                            exit_with_literal_op,
  output logic                            interrupt_exit_op,
  output logic                            vector_op,
  output logic                            low_wr,
  output logic [pcsp_pkg::LOW_W-1:0]      low_wr_data,
  output logic [pcsp_pkg::TGT_W-1:0]      branch_target
);
  import pcsp_pkg::*;
  wire logic busy;
  assign busy                 = (op_code != 4'h0);
  assign fetch_adv            = (op_code == 4'h1);
  assign jump_op              = (op_code == 4'h2);
  assign call_op              = (op_code == 4'h3);
  assign return_op            = (op_code == 4'h4);
  assign exit_with_literal_op = (op_code == 4'h5);
  assign interrupt_exit_op    = (op_code == 4'h6);
  assign vector_op            = (op_code == 4'h7);
  assign low_wr               = (op_code == 4'h8);
  // Operand lines show inverted data when no op is issued
  assign branch_target = busy ? op_arg[TGT_W-1:0] : ~op_arg[TGT_W-1:0];
  assign low_wr_data   = busy ? op_arg[LOW_W-1:0] : ~op_arg[LOW_W-1:0];
endmodule
`default_nettype wire

// >>> pcsp_core_tb_top.sv
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ns
`default_nettype none
module pcsp_core_tb_top;
  import pcsp_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              latch_wr = 1'b0;
  logic [7:0]        latch_wr_data = 8'h00;
  logic [3:0]        op_code = 4'h0;
  logic [12:0]       op_arg = 13'h0000;
  wire logic         f_adv, j_op, c_op, r_op, rl_op, ri_op, v_op, l_wr;
  wire logic [7:0]   l_data;
  wire logic [10:0]  tgt;
  logic [PC_W-1:0]   fetch_addr;
  logic [7:0]        pc_low_byte, pc_high_latch;
  logic [PC_W-1:0]   pushed [9];
  logic [PC_W-1:0]   e;
  int                n_errors = 0;
  int                checks = 0;
  int                cycles = 0;

  pcsp_decoder_model pcsp_decoder_model_inst (.op_code(op_code),
    .op_arg(op_arg), .fetch_adv(f_adv), .jump_op(j_op), .call_op(c_op),
    .return_op(r_op), .exit_with_literal_op(rl_op),
    .interrupt_exit_op(ri_op), .vector_op(v_op), .low_wr(l_wr),
    .low_wr_data(l_data), .branch_target(tgt));

  pcsp_core pcsp_core_inst (.clock(clock), .rst_n(rst_n), .fetch_adv(f_adv),
    .jump_op(j_op), .call_op(c_op), .branch_target(tgt), .return_op(r_op),
    .exit_with_literal_op(rl_op), .interrupt_exit_op(ri_op),
    .vector_op(v_op), .low_wr(l_wr), .low_wr_data(l_data),
    .latch_wr(latch_wr), .latch_wr_data(latch_wr_data),
    .fetch_addr(fetch_addr), .pc_low_byte(pc_low_byte),
    .pc_high_latch(pc_high_latch));

  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic op(input logic [3:0] c, input logic [12:0] a);
    @(posedge clock);
    op_code <= c;
    op_arg  <= a;
    @(posedge clock);
    op_code <= 4'h0;
    #1;
  endtask

  task automatic set_latch(input logic [7:0] v);
    @(posedge clock);
    latch_wr      <= 1'b1;
    latch_wr_data <= v;
    @(posedge clock);
    latch_wr      <= 1'b0;
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_after_reset();
    chk(fetch_addr, 13'h0000, "reset pc");
    chk({5'h00, pc_high_latch}, 13'h0000, "reset latch");
  endtask

  task automatic t_low_write_carry();
    set_latch(8'he1);
    op(4'h8, 13'h00ff);
    chk(fetch_addr, 13'h01ff, "low write");
    chk({5'h00, pc_low_byte}, 13'h00ff, "low read");
    op(4'h1, 13'h0000);
    chk(fetch_addr, 13'h0200, "advance carry");
    chk({5'h00, pc_low_byte}, 13'h0000, "low after carry");
    op(4'h8, 13'h0005);
    chk(fetch_addr, 13'h0105, "computed branch");
  endtask

  task automatic t_jump_page();
    set_latch(8'h1f);
    op(4'h2, 13'h0123);
    chk(fetch_addr, 13'h1923, "jump page 3");
  endtask

  task automatic t_call_return();
    set_latch(8'h08);
    op(4'h3, 13'h0055);
    chk(fetch_addr, 13'h0855, "call page 1");
    set_latch(8'h10);
    op(4'h4, 13'h0000);
    chk(fetch_addr, 13'h1923, "return all bits");
    chk({5'h00, pc_high_latch}, 13'h0010, "latch after pop");
  endtask

  task automatic t_circular();
    set_latch(8'h00);
    e = 13'h1923;
    // Nine pushes back to back, then nine pops back to back
    for (int i = 0; i < 18; i++) begin
      @(posedge clock);
      if (i < 9) begin
        op_code <= (i == 4) ? 4'h7 : 4'h3;
        op_arg  <= 13'h0010 + 13'(i);
      end else begin
        op_code <= 4'h4 + 4'((i - 9) % 3);
      end
      if (i > 0) begin
        #1;
        chk(fetch_addr, e, "stack step");
      end
      if (i < 9) begin
        pushed[i] = e;
        e = (i == 4) ? VEC_DFLT : 13'h0010 + 13'(i);
      end else begin
        e = pushed[(i == 17) ? 8 : 17 - i];
      end
    end
    @(posedge clock);
    op_code <= 4'h0;
    #1;
    chk(fetch_addr, e, "last pop");
    chk({5'h00, pc_high_latch}, 13'h0000, "latch kept");
  endtask

  task automatic t_mid_reset();
    set_latch(8'h1f);
    op(4'h8, 13'h00aa);
    chk(fetch_addr, 13'h1faa, "upper loaded");
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk(fetch_addr, 13'h0000, "mid reset pc");
    chk({5'h00, pc_high_latch}, 13'h0000, "mid reset latch");
    op(4'h1, 13'h0000);
    chk(fetch_addr, 13'h0001, "advance after reset");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    t_after_reset();
    t_low_write_carry();
    t_jump_page();
    t_call_return();
    t_circular();
    t_mid_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
